/* File: rtl/hbc_half_bridge_ctrl.sv */
// Top of the half-bridge chopper control: interface decode, chopping, regs.
//
// Contract
// RL1 - Floating select pin picks independent half-bridges.
// RL2 - Awake: select pin and third input choose interface.
// RL3 - Four-input pairs: coast, reverse, forward, brake.
// RL4 - Independent: each input drives only its output.
// RL5 - Independent: 0 grounds output, 1 to supply.
// RL6 - Independent outputs: high side or low side.
// RL7 - Standby request low floats all four outputs.
// RL8 - Trip stops pair drive for the off-time.
// RL9 - Blanking ignores trip; sets minimum on-time.
// RL10 - Comparator result is the only trip source.
// RL11 - Torque select halves trip reference dynamically.
// RL12 - Off-time: quarter fast, then three quarters slow.
// RL13 - Slow decay turns both low sides on.
// RL14 - Fast decay turns all switches of pair off.
// RL15 - Regulation acts per pair, also when independent.
// RL16 - Host avoids regulation for independent loads.
// RL17 - Host full-steps four-input with 90 degree offset.
// RL18 - Host full-steps two-input, third input grounded.
// RL19 - Host half-steps forward, reverse, coast, 45 degrees.
// RL20 - Host half-steps only in four-input operation.
// RL21 - Counters time off-time and blanking intervals.
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module hbc_half_bridge_ctrl
  import hbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_request_n_i,
  input wire logic mode_sel_i,
  input wire logic mode_sel_float_i,
  input wire logic half_a_ctrl_i,
  input wire logic half_b_ctrl_i,
  input wire logic half_c_ctrl_i,
  input wire logic half_d_ctrl_i,
  input wire logic pair_ab_sense_trip_i,
  input wire logic pair_cd_sense_trip_i,
  input wire logic torque_halve_sel_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic half_a_node_hs_o,
  output logic half_a_node_ls_o,
  output logic half_b_node_hs_o,
  output logic half_b_node_ls_o,
  output logic half_c_node_hs_o,
  output logic half_c_node_ls_o,
  output logic half_d_node_hs_o,
  output logic half_d_node_ls_o,
  output logic trip_reference_half_o
);

  hbc_mode_e mode;
  logic [3:0] ctrl;
  logic [3:0] br_ab;
  logic [3:0] br_cd;
  logic [3:0] hs_raw;
  logic [3:0] ls_raw;
  logic [3:0] hs_q;
  logic [3:0] ls_q;
  logic [3:0] next_hs;
  logic [3:0] next_ls;
  logic [1:0] trip;
  logic [1:0] drive_active;
  logic chop_en;
  hbc_chop_e pair_state [2];
  logic [7:0] phase_bits;
  logic trq_q;
  logic next_trq;
  logic ctrl_chop_en;
  logic next_ctrl_chop_en;
  logic wait_q;
  logic next_wait;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata;

  // Map a two-input pair onto its full bridge.
  function automatic logic [3:0] bridge_of(input logic [1:0] sel);
    logic [3:0] br;
    br = HBC_BR_COAST;
    unique case (sel)
      2'b00: br = HBC_BR_COAST;
      2'b01: br = HBC_BR_REV;
      2'b10: br = HBC_BR_FWD;
      2'b11: br = HBC_BR_BRAKE;
    endcase
    return br;
  endfunction

  assign ctrl = {half_d_ctrl_i, half_c_ctrl_i, half_b_ctrl_i, half_a_ctrl_i};
  // The comparator outputs are the sole trip sources of each pair.
  // RL10 comparator sole trip
  assign trip = {pair_cd_sense_trip_i, pair_ab_sense_trip_i};

  // Interface selection; the pin is not latched, so a change acts at once.
  always_comb
  begin
    // RL7 standby floats outputs
    if (!standby_request_n_i)
    begin
      mode = HBC_MODE_SLEEP;
    end
    // RL1 floating select pin
    else if (mode_sel_float_i)
    begin
      mode = HBC_MODE_INDEP;
    end
    // RL2 select pin decode
    else if (!mode_sel_i)
    begin
      mode = HBC_MODE_FOUR;
    end
    else if (!half_c_ctrl_i)
    begin
      mode = HBC_MODE_TWO;
    end
    else
    begin
      mode = HBC_MODE_PAR;
    end
  end

  // Bridge patterns before chopping for the paired interfaces.
  always_comb
  begin
    br_ab = HBC_BR_COAST;
    br_cd = HBC_BR_COAST;
    unique case (mode)
      HBC_MODE_FOUR:
      begin
        // RL3 four-input truth table
        br_ab = bridge_of({half_a_ctrl_i, half_b_ctrl_i});
        br_cd = bridge_of({half_c_ctrl_i, half_d_ctrl_i});
      end
      HBC_MODE_TWO:
      begin
        // Two-input mode never coasts: one side is always driven.
        br_ab = half_a_ctrl_i ? HBC_BR_FWD : HBC_BR_REV;
        br_cd = half_b_ctrl_i ? HBC_BR_FWD : HBC_BR_REV;
      end
      HBC_MODE_PAR:
      begin
        br_ab = bridge_of({half_a_ctrl_i, half_b_ctrl_i});
        br_cd = bridge_of({half_a_ctrl_i, half_b_ctrl_i});
      end
      default:
      begin
        br_ab = HBC_BR_COAST;
        br_cd = HBC_BR_COAST;
      end
    endcase
  end

  // Raw switch demand per half-bridge.
  always_comb
  begin
    hs_raw = {br_cd[1], br_cd[3], br_ab[1], br_ab[3]};
    ls_raw = {br_cd[0], br_cd[2], br_ab[0], br_ab[2]};
    if (mode == HBC_MODE_INDEP)
    begin
      // RL4 one input per output
      // RL5 zero grounds, one drives supply
      // RL6 exactly two states
      hs_raw = ctrl;
      ls_raw = ~ctrl;
    end
    else if (mode == HBC_MODE_SLEEP)
    begin
      hs_raw = 4'h0;
      ls_raw = 4'h0;
    end
  end

  // A pair is driving while any high side of it is asked for.
  assign drive_active = {|hs_raw[3:2], |hs_raw[1:0]};
  assign chop_en = ctrl_chop_en & standby_request_n_i;

  // One chopper per bridge pair sharing a sense input.
  // RL15 regulation per pair
  for (genvar p = 0; p < 2; p++)
  begin : g_pair
    hbc_pair_chopper u_chop (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .chop_en_i(chop_en),
      .drive_active_i(drive_active[p]),
      .trip_i(trip[p]),
      .state_o(pair_state[p])
    );
    assign phase_bits[4*p +: 4] = pair_state[p];
  end

  // Apply the decay phase of each pair on top of the raw demand.
  always_comb
  begin
    next_hs = hs_raw;
    next_ls = ls_raw;
    for (int p = 0; p < 2; p++)
    begin
      // RL14 fast decay all off
      if (pair_state[p] == HBC_FAST)
      begin
        next_hs[2*p +: 2] = 2'b00;
        next_ls[2*p +: 2] = 2'b00;
      end
      // RL13 slow decay low sides
      else if (pair_state[p] == HBC_SLOW && mode != HBC_MODE_SLEEP)
      begin
        next_hs[2*p +: 2] = 2'b00;
        next_ls[2*p +: 2] = 2'b11;
      end
    end
    // RL11 torque halving select
    next_trq = torque_halve_sel_i;
  end

  // Output stage registers; all switches start off.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hs_q <= 4'h0;
      ls_q <= 4'h0;
      trq_q <= 1'b0;
    end
    else
    begin
      hs_q <= next_hs;
      ls_q <= next_ls;
      trq_q <= next_trq;
    end
  end

  assign half_a_node_hs_o = hs_q[0];
  assign half_a_node_ls_o = ls_q[0];
  assign half_b_node_hs_o = hs_q[1];
  assign half_b_node_ls_o = ls_q[1];
  assign half_c_node_hs_o = hs_q[2];
  assign half_c_node_ls_o = ls_q[2];
  assign half_d_node_hs_o = hs_q[3];
  assign half_d_node_ls_o = ls_q[3];
  assign trip_reference_half_o = trq_q;

  // Register slave: one wait cycle, then a one-cycle answer window.
  always_comb
  begin
    next_wait = 1'b1;
    next_rdata = rdata_q;
    next_ctrl_chop_en = ctrl_chop_en;
    if ((avs_read_i || avs_write_i) && wait_q)
    begin
      next_wait = 1'b0;
      next_rdata = 32'h0000_0000;
      if (avs_read_i && avs_address_i == HBC_CTRL_OFS)
      begin
        next_rdata[CTRL_CHOP_EN_BIT] = ctrl_chop_en;
      end
      else if (avs_read_i && avs_address_i == HBC_STAT_OFS)
      begin
        next_rdata[STAT_MODE_LSB +: 5] = mode;
        next_rdata[STAT_PHASE_LSB +: 8] = phase_bits;
        next_rdata[STAT_HS_LSB +: 4] = hs_q;
        next_rdata[STAT_LS_LSB +: 4] = ls_q;
        next_rdata[STAT_TRQ_BIT] = trq_q;
      end
    end
    // Writes take effect on the edge that completes the transfer.
    if (avs_write_i && !wait_q && avs_address_i == HBC_CTRL_OFS &&
        avs_byteenable_i[0])
    begin
      next_ctrl_chop_en = avs_writedata_i[CTRL_CHOP_EN_BIT];
    end
  end

  // Register slave state.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      ctrl_chop_en <= CTRL_CHOP_EN_RST;
    end
    else
    begin
      wait_q <= next_wait;
      rdata_q <= next_rdata;
      ctrl_chop_en <= next_ctrl_chop_en;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;

  AST_SLEEP_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
    !standby_request_n_i |=> (hs_q == 4'h0 && ls_q == 4'h0))
    else $error("Outputs not floating in standby.");
  AST_INDEP_MAP: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
    (mode == HBC_MODE_INDEP && pair_state[0] inside {HBC_BLANK, HBC_SENSE}
     && pair_state[1] inside {HBC_BLANK, HBC_SENSE})
    |=> (hs_q == $past(ctrl) && ls_q == ~$past(ctrl)))
    else $error("Independent output does not follow its input.");
  AST_NO_SHOOT: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    (hs_q & ls_q) == 4'h0)
    else $error("High and low side on together.");
  AST_FOUR_BRAKE: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    (mode == HBC_MODE_FOUR && half_a_ctrl_i && half_b_ctrl_i
     && pair_state[0] != HBC_FAST)
    |=> ls_q[1:0] == 2'b11 && hs_q[1:0] == 2'b00)
    else $error("Four-input brake not applied.");
  AST_SLOW_LS: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
    (pair_state[1] == HBC_SLOW && standby_request_n_i)
    |=> ls_q[3:2] == 2'b11 && hs_q[3:2] == 2'b00)
    else $error("Slow decay did not turn both low sides on.");
  AST_TRQ: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
    $changed(torque_halve_sel_i) |=> trip_reference_half_o ==
    $past(torque_halve_sel_i))
    else $error("Trip reference select did not follow torque input.");
  AST_BUS_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
    ((avs_read_i || avs_write_i) && avs_waitrequest_o)
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("Bus answer not given one cycle after request.");
  CVR_INDEP: cover property (@(posedge clk_i) disable iff (rst_i)
    mode == HBC_MODE_INDEP ##1 hs_q != 4'h0);
  CVR_PAR_FWD: cover property (@(posedge clk_i) disable iff (rst_i)
    mode == HBC_MODE_PAR ##1 hs_q == 4'h5);

endmodule
`default_nettype wire

/* File: rtl/hbc_pair_chopper.sv */
// Fixed off-time chopper with blanking and mixed decay for one bridge pair.
`timescale 1ns/1ns
`default_nettype none
module hbc_pair_chopper
  import hbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic chop_en_i,
  input wire logic drive_active_i,
  input wire logic trip_i,
  output var hbc_chop_e state_o
);

  localparam int AST_BLANK = BLANK_CYC;
  localparam int AST_FAST = FAST_CYC;

  hbc_chop_e state;
  hbc_chop_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  // Phase sequencer; loss of enable returns to blanking from any phase, loss of drive only from sensing.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      HBC_BLANK:
      begin
        // RL9 blanking minimum on-time
        if (!drive_active_i || !chop_en_i)
        begin
          next_cnt = '0;
        end
        else if (cnt == CNT_W'(BLANK_CYC - 1))
        begin
          next_state = HBC_SENSE;
          next_cnt = '0;
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      HBC_SENSE:
      begin
        // RL8 trip starts off-time
        if (!drive_active_i || !chop_en_i)
        begin
          next_state = HBC_BLANK;
        end
        else if (trip_i)
        begin
          next_state = HBC_FAST;
        end
        next_cnt = '0;
      end
      HBC_FAST:
      begin
        // RL12 quarter fast decay
        if (!chop_en_i)
        begin
          next_state = HBC_BLANK;
          next_cnt = '0;
        end
        else if (cnt == CNT_W'(FAST_CYC - 1))
        begin
          next_state = HBC_SLOW;
          next_cnt = '0;
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      HBC_SLOW:
      begin
        // RL21 off-time counter ends
        if (!chop_en_i || cnt == CNT_W'(SLOW_CYC - 1))
        begin
          next_state = HBC_BLANK;
          next_cnt = '0;
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      default:
      begin
        next_state = HBC_BLANK;
        next_cnt = '0;
      end
    endcase
  end

  // Phase and counter registers.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= HBC_BLANK;
      cnt <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign state_o = state;

  AST_BLANK_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
    $rose(state == HBC_SENSE) |-> $past(state == HBC_BLANK, AST_BLANK))
    else $error("Sensing began before the blanking interval ended.");
  AST_TRIP_STOP: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    (state == HBC_SENSE && trip_i && chop_en_i && drive_active_i)
    |=> state == HBC_FAST)
    else $error("A trip did not start the off-time.");
  AST_BLANK_IGNORE: assert property (@(posedge clk_i) // RL9
    disable iff (rst_i) state == HBC_BLANK |=> state != HBC_FAST)
    else $error("A trip was taken during blanking.");
  AST_FAST_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
    $rose(state == HBC_SLOW) |-> $past(state == HBC_FAST, AST_FAST))
    else $error("Fast decay did not last a quarter of the off-time.");
  CVR_TRIP: cover property (@(posedge clk_i) disable iff (rst_i)
    state == HBC_SENSE ##1 state == HBC_FAST);
  CVR_SLOW_END: cover property (@(posedge clk_i) disable iff (rst_i)
    state == HBC_SLOW ##1 state == HBC_BLANK);

endmodule
`default_nettype wire

/* File: rtl/hbc_pkg.sv */
// Constants, register map and state types of the half-bridge chopper block.
`default_nettype none
package hbc_pkg;

  // Clock and chopping times, in ns, with derived cycle counts.
  localparam int CLK_PERIOD_NS = 40;
  localparam int CHOP_OFF_TIME_NS = 16000;
  localparam int SENSE_BLANK_TIME_NS = 1000;
  localparam int OFF_CYC =
    (CHOP_OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAST_CYC = OFF_CYC / 4;
  localparam int SLOW_CYC = OFF_CYC - FAST_CYC;
  localparam int BLANK_CYC =
    (SENSE_BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 9;

  // Register byte offsets and field positions.
  localparam logic [3:0] HBC_CTRL_OFS = 4'h0;
  localparam logic [3:0] HBC_STAT_OFS = 4'h4;
  localparam int CTRL_CHOP_EN_BIT = 0;
  localparam logic CTRL_CHOP_EN_RST = 1'b1;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_PHASE_LSB = 8;
  localparam int STAT_HS_LSB = 16;
  localparam int STAT_LS_LSB = 20;
  localparam int STAT_TRQ_BIT = 24;

  // Full-bridge patterns {hs_x, ls_x, hs_y, ls_y}.
  localparam logic [3:0] HBC_BR_COAST = 4'h0;
  localparam logic [3:0] HBC_BR_REV = 4'h6;
  localparam logic [3:0] HBC_BR_FWD = 4'h9;
  localparam logic [3:0] HBC_BR_BRAKE = 4'h5;

  // Chopping phase of one bridge pair.
  typedef enum logic [3:0] {
    HBC_BLANK = 4'b0001,
    HBC_SENSE = 4'b0010,
    HBC_FAST = 4'b0100,
    HBC_SLOW = 4'b1000
  } hbc_chop_e;

  // Interface selected from the pins.
  typedef enum logic [4:0] {
    HBC_MODE_SLEEP = 5'b00001,
    HBC_MODE_FOUR = 5'b00010,
    HBC_MODE_TWO = 5'b00100,
    HBC_MODE_PAR = 5'b01000,
    HBC_MODE_INDEP = 5'b10000
  } hbc_mode_e;

endpackage
`default_nettype wire

/* File: verification/hbc_half_bridge_ctrl_tb.sv */
// Self-checking bench for the half-bridge chopper control block.
`timescale 1ns/1ns
`default_nettype none
module hbc_half_bridge_ctrl_tb
  import hbc_pkg::*;
;
  localparam int LIM = 80;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cmd = 8'h00;
  logic hold = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [3:0] pv;
  logic [7:0] e;
  wire logic [7:0] pins;
  wire logic [7:0] nodes;
  wire logic [31:0] rdata;
  wire logic trip_ab;
  wire logic trip_cd;
  wire logic href;
  wire logic wrq;
  int errors = 0;
  int n_checks = 0;

  // Clock at 25 MHz.
  always #20 clk = ~clk;

  hbc_host_model #(.LIM(LIM)) host (.clk_i(clk), .cmd_i(cmd),
    .hold_i(hold), .half_ref_i(href), .ab_hs_i(nodes[7] | nodes[5]),
    .cd_hs_i(nodes[3] | nodes[1]), .pins_o(pins), .trip_ab_o(trip_ab),
    .trip_cd_o(trip_cd));

  hbc_half_bridge_ctrl dut (.clk_i(clk), .rst_i(rst),
    .standby_request_n_i(pins[7]), .mode_sel_i(pins[6]),
    .mode_sel_float_i(pins[5]), .torque_halve_sel_i(pins[4]),
    .half_a_ctrl_i(pins[3]), .half_b_ctrl_i(pins[2]),
    .half_c_ctrl_i(pins[1]), .half_d_ctrl_i(pins[0]),
    .pair_ab_sense_trip_i(trip_ab), .pair_cd_sense_trip_i(trip_cd),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wrq),
    .half_a_node_hs_o(nodes[7]), .half_a_node_ls_o(nodes[6]),
    .half_b_node_hs_o(nodes[5]), .half_b_node_ls_o(nodes[4]),
    .half_c_node_hs_o(nodes[3]), .half_c_node_ls_o(nodes[2]),
    .half_d_node_hs_o(nodes[1]), .half_d_node_ls_o(nodes[0]),
    .trip_reference_half_o(href));

  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic stuck();
    errors++;
    $display("Error wait bound used up");
    conclude();
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] x,
                         input logic [31:0] s);
    n_checks++;
    if (s !== x)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic chk_cnt(input string nm, input int lo, input int hi,
                         input int s);
    n_checks++;
    if (s < lo || s > hi)
    begin
      errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask

  // One Avalon transfer; the request stands until waitrequest is low.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wrq !== 1'b0 && n < 50);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wrq !== 1'b0)
      stuck();
  endtask

  // Counts edges for which pair ab shows pattern v.
  task automatic run(input logic [3:0] v, output int c);
    c = 0;
    while (nodes[7:4] === v && c < 2000)
    begin
      @(posedge clk);
      c++;
    end
    if (c >= 2000)
      stuck();
  endtask

  // Measures one whole chopping cycle of pair ab, driven forward.
  task automatic chop(input int lo, input int hi);
    int c;
    int on_c;
    int fast_c;
    int slow_c;
    c = 0;
    while (nodes[7:4] !== 4'b0101 && c < 2000)
    begin
      @(posedge clk);
      c++;
    end
    if (c >= 2000)
      stuck();
    run(4'b0101, c);
    run(4'b1001, on_c);
    run(4'b0000, fast_c);
    run(4'b0101, slow_c);
    chk_cnt("on time", lo, hi, on_c);
    chk_cnt("fast", FAST_CYC, FAST_CYC, fast_c);
    chk_cnt("slow", SLOW_CYC, SLOW_CYC, slow_c);
  endtask

  // Full-bridge pattern {hs_x, ls_x, hs_y, ls_y} from two inputs.
  function automatic logic [3:0] br(input logic x, input logic y);
    case ({x, y})
      2'b01: return 4'b0110;
      2'b10: return 4'b1001;
      2'b11: return 4'b0101;
      default: return 4'b0000;
    endcase
  endfunction

  // Main sequence: registers, decode of every mode, then chopping.
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_reg("nodes reset", 32'h0, {24'h0, nodes});
    bus(1'b0, HBC_CTRL_OFS, 32'h0);
    chk_reg("ctrl reset", 32'h1, rdat);
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk_reg("unmapped", 32'h0, rdat);
    bus(1'b0, HBC_CTRL_OFS, 32'h0);
    chk_reg("ctrl kept", 32'h1, rdat);
    bus(1'b1, HBC_CTRL_OFS, 32'h0);
    // Modes: 0 four, 1 two, 2 parallel, 3 floating select, 4 standby.
    for (int m = 0; m < 5; m++)
    begin
      for (int p = 0; p < 16; p++)
      begin
        pv = 4'(p);
        if (m == 1)
          pv[1] = 1'b0;
        if (m == 2)
          pv[1] = 1'b1;
        cmd <= {m != 4, m != 0, m == 3, 1'b0, pv};
        case (m)
          0: e = {br(pv[3], pv[2]), br(pv[1], pv[0])};
          1: e = {br(pv[3], ~pv[3]), br(pv[2], ~pv[2])};
          2: e = {br(pv[3], pv[2]), br(pv[3], pv[2])};
          3: e = {pv[3], ~pv[3], pv[2], ~pv[2], pv[1], ~pv[1], pv[0],
                  ~pv[0]};
          default: e = 8'h00;
        endcase
        repeat (3) @(posedge clk);
        chk_reg("nodes", 32'(e), 32'(nodes));
      end
      bus(1'b0, HBC_STAT_OFS, 32'h0);
      chk_reg("mode", (m == 4) ? 32'h1 : 32'h1 << (m + 1),
              {27'h0, rdat[4:0]});
    end
    // Chopper off: a stuck trip must not interrupt the drive.
    hold <= 1'b1;
    cmd <= 8'h88;
    repeat (100) @(posedge clk);
    chk_reg("no chop", 32'h90, {24'h0, nodes});
    bus(1'b1, HBC_CTRL_OFS, 32'h1);
    chop(BLANK_CYC, BLANK_CYC + 3);
    cmd <= 8'hea;
    chop(BLANK_CYC, BLANK_CYC + 3);
    hold <= 1'b0;
    cmd <= 8'h88;
    chop(LIM, LIM + 4);
    cmd <= 8'h98;
    chop(LIM / 2, LIM / 2 + 4);
    chk_reg("half ref", 32'h1, {31'h0, href});
    bus(1'b0, HBC_STAT_OFS, 32'h0);
    chk_reg("torque bit", 32'h1, {31'h0, rdat[STAT_TRQ_BIT]});
    conclude();
  end
endmodule
`default_nettype wire

/* File: verification/hbc_host_model.sv */
// Host pins and sense comparators facing the chopper control block.
`timescale 1ns/1ns
`default_nettype none
module hbc_host_model #(
  parameter int LIM = 80
) (
  input wire logic clk_i,
  input wire logic [7:0] cmd_i,
  input wire logic hold_i,
  input wire logic half_ref_i,
  input wire logic ab_hs_i,
  input wire logic cd_hs_i,
  output logic [7:0] pins_o,
  output logic trip_ab_o,
  output logic trip_cd_o
);
  int cur_ab = 0;
  int cur_cd = 0;
  int lim;

  // Pins settle on the first edge, well inside the reset hold.
  // host GPIO pattern
  always @(posedge clk_i)
    pins_o <= cmd_i;

  // Current climbs while a high side is on; a stuck load trips at once.
  // comparator against reference
  always @(posedge clk_i)
  begin
    lim = half_ref_i ? LIM / 2 : LIM;
    cur_ab <= ab_hs_i ? cur_ab + 1 : 0;
    cur_cd <= cd_hs_i ? cur_cd + 1 : 0;
    trip_ab_o <= hold_i | (cur_ab >= lim);
    trip_cd_o <= hold_i | (cur_cd >= lim);
  end
endmodule
`default_nettype wire
